// >>> core/batt_temp_comparator.v
`timescale 1ns/100ps
`default_nettype none
`include "charger_ilim_regs.vh"

// ----------------------------------------------------------------------
// Threshold comparator with hysteresis, held clear while disabled.
// ----------------------------------------------------------------------
module batt_temp_comparator (
    input  wire        clk_i,
    input  wire        reset_i,
    input  wire        enable_i,
    input  wire        above_mode_i,
    input  wire [7:0]  temp_i,
    input  wire [7:0]  threshold_i,
    output reg         trip_o
);
    wire [7:0] release_above = threshold_i - `BATT_HYST_C;
    wire [7:0] release_below = threshold_i + `BATT_HYST_C;

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            trip_o <= 1'b0;
        end else if (!enable_i) begin
            trip_o <= 1'b0;
        end else if (above_mode_i) begin
            if (temp_i >= threshold_i)
                trip_o <= 1'b1;
            else if (temp_i < release_above)
                trip_o <= 1'b0;
        end else begin
            if (temp_i <= threshold_i)
                trip_o <= 1'b1;
            else if (temp_i > release_below)
                trip_o <= 1'b0;
        end
    end
endmodule // batt_temp_comparator
`default_nettype wire

// >>> core/charger_ilim_regs.vh
`ifndef CHARGER_ILIM_REGS_VH
`define CHARGER_ILIM_REGS_VH

// Register map.
`define ILIM_CTRL_ADDR      8'h94
`define ILIM_CTRL_RESET     8'h68
`define ILIM_CODE_MSB       7
`define ILIM_CODE_LSB       3
`define ILIM_CODE_MAX       5'h14

// Default charge current cap and die temperature steps.
`define CHG_DEFAULT_MA      11'h064
`define TEMP_STEP0_C        8'h50
`define TEMP_STEP1_C        8'h5f
`define TEMP_STEP2_C        8'h6e
`define TEMP_STEP3_C        8'h7d
`define TEMP_STEP3_REL_C    8'h78
`define TEMP_HYST_C         8'h05
`define BATT_HYST_C         8'h03

// Thermal states, one-hot.
`define TS_FULL             5'h01
`define TS_HALF             5'h02
`define TS_QUARTER          5'h04
`define TS_EIGHTH           5'h08
`define TS_FLOOR            5'h10

`endif

// >>> core/charger_input_limit_thermal_regulation.v
// Behaviour
// - On charger arrival, enable regulator in selected mode, cap charge at 100 mA.
// - Compare input current to limit; reduce charger current while exceeded.
// - Current sensing runs only while input valid; sense amplifier off otherwise.
// - Counted input current includes charger bias, battery charge and system load.
// - Input voltage below desired level raises the charger event interrupt.
// - Limit register at 0x94, code in bits 7..3 read/write, low bits reserved.
// - Codes 0 to 8 select 10 to 50 mA in 5 mA steps.
// - Codes 9 to 20 select 100 to 1500 mA; higher codes reserved.
// - Battery thermistor monitoring off when no valid charger present.
// - Battery comparators have 3 degree hysteresis; hot and cold thresholds selectable.
// - Die temperature above setpoint-selected threshold reduces target charge current; here the 100 mA cap and step floor leave charge_target_ma_o unchanged.
// - Setpoint 00 steps: 50% at 80, 25% at 95, 12.5% at 110, 100 mA at 125.
// - Setpoint 01, 10, 11 drop lower steps; 125 degree floor always applies.
// - Current steps are restored after temperature falls below a margin, or when a setpoint change drops the active step.
// - Each thermal state change pulses the thermal interrupt.
// - Thermal regulation never alters the charger good flag.
// - Falling more than 5 degrees below a step threshold restores the previous step.
// - Floor holds 100 mA until below 120, then 12.5%; never below 100 mA.
`timescale 1ns/100ps
`default_nettype none
`include "charger_ilim_regs.vh"

module charger_input_limit_thermal_regulation (
    input  wire        clk_i,
    input  wire        reset_i,
    // Register port.
    input  wire [7:0]  reg_addr_i,
    input  wire [7:0]  reg_wdata_i,
    input  wire        reg_write_i,
    input  wire        reg_read_i,
    output reg  [7:0]  reg_rdata_o,
    // Charger input and supervision.
    input  wire        input_valid_internal_i,
    input  wire        charger_operation_select_i,
    input  wire [10:0] charge_current_ma_i,
    input  wire [10:0] system_load_ma_i,
    input  wire [10:0] charger_bias_ma_i,
    input  wire        input_voltage_low_i,
    input  wire [2:0]  charger_state_sense_i,
    input  wire [10:0] cc_current_ma_i,
    // Temperatures in degrees C.
    input  wire [7:0]  die_temp_i,
    input  wire [1:0]  die_temp_setpoint_select_i,
    input  wire [7:0]  battery_temp_i,
    input  wire [7:0]  battery_hot_threshold_i,
    input  wire [7:0]  battery_cold_threshold_i,
    // Outputs.
    output reg         linear_on_o,
    output reg         charge_on_o,
    output reg         sense_amp_enable_o,
    output reg         input_limit_active_o,
    output reg  [10:0] charge_target_ma_o,
    output reg         charger_event_irq_o,
    output reg         thermal_state_irq_o,
    output reg         thermal_loop_sense_o,
    output reg         charger_good_flag_o,
    output reg         battery_hot_o,
    output reg         battery_cold_o
);

    // ------------------------------------------------------------------
    // Thermal states.
    // ------------------------------------------------------------------
    localparam [4:0] ST_FULL    = `TS_FULL;
    localparam [4:0] ST_HALF    = `TS_HALF;
    localparam [4:0] ST_QUARTER = `TS_QUARTER;
    localparam [4:0] ST_EIGHTH  = `TS_EIGHTH;
    localparam [4:0] ST_FLOOR   = `TS_FLOOR;

    localparam [7:0] ILIM_RESET_BYTE = `ILIM_CTRL_RESET;

    reg  [4:0]  ilim_code_q;
    reg  [4:0]  therm_q;
    reg  [4:0]  therm_d;
    reg         vlow_q;
    reg         valid_q;
    reg  [10:0] reduce_ma_q;
    wire [10:0] limit_ma;
    wire        hot_trip;
    wire        cold_trip;

    // Lowest thermal step that a setpoint code enables: 1 half, 2 quarter, 3 eighth.
    function [1:0] step_depth;
        input [1:0] sel;
        begin
            case (sel)
                2'b00:   step_depth = 2'd3;
                2'b01:   step_depth = 2'd2;
                2'b10:   step_depth = 2'd1;
                default: step_depth = 2'd0;
            endcase
        end
    endfunction

    // Entry threshold of a reduction step for a setpoint code.
    function [7:0] step_threshold;
        input [1:0] sel;
        input [1:0] step;
        reg   [3:0] idx;
        begin
            idx = {2'b00, step} + {2'b00, sel} - 4'd1;
            case (idx)
                4'd0:    step_threshold = `TEMP_STEP0_C;
                4'd1:    step_threshold = `TEMP_STEP1_C;
                default: step_threshold = `TEMP_STEP2_C;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // Register port.
    // ------------------------------------------------------------------
    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ilim_code_q <= ILIM_RESET_BYTE[`ILIM_CODE_MSB:`ILIM_CODE_LSB];
            reg_rdata_o <= 8'h00;
        end else begin
            if (reg_write_i && reg_addr_i == `ILIM_CTRL_ADDR &&
                reg_wdata_i[`ILIM_CODE_MSB:`ILIM_CODE_LSB] <= `ILIM_CODE_MAX) begin
                ilim_code_q <= reg_wdata_i[`ILIM_CODE_MSB:`ILIM_CODE_LSB];
            end
            if (reg_read_i) begin
                reg_rdata_o <= (reg_addr_i == `ILIM_CTRL_ADDR) ?
                               {ilim_code_q, 3'b000} : 8'h00;
            end
        end
    end

    ilim_code_decode u_decode (
        .code_i     (ilim_code_q),
        .limit_ma_o (limit_ma)
    );

    // ------------------------------------------------------------------
    // Input current limit loop.
    // ------------------------------------------------------------------
    wire [12:0] total_ma = {2'b00, charge_current_ma_i} + {2'b00, system_load_ma_i} +
                           {2'b00, charger_bias_ma_i};
    wire        over_limit = valid_q && (total_ma > {2'b00, limit_ma});

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            valid_q              <= 1'b0;
            sense_amp_enable_o   <= 1'b0;
            input_limit_active_o <= 1'b0;
            reduce_ma_q          <= 11'h000;
            linear_on_o          <= 1'b0;
            charge_on_o          <= 1'b0;
            vlow_q               <= 1'b0;
            charger_event_irq_o  <= 1'b0;
            charger_good_flag_o  <= 1'b0;
        end else begin
            valid_q              <= input_valid_internal_i;
            sense_amp_enable_o   <= input_valid_internal_i;
            input_limit_active_o <= over_limit;
            if (over_limit) begin
                // A sum beyond the 11-bit range saturates the cut instead of wrapping.
                reduce_ma_q <= (total_ma[12:11] != 2'b00) ? 11'h7ff :
                               total_ma[10:0] - limit_ma;
            end else begin
                reduce_ma_q <= 11'h000;
            end
            linear_on_o <= input_valid_internal_i && !charger_operation_select_i;
            charge_on_o <= input_valid_internal_i && charger_operation_select_i;
            vlow_q              <= input_voltage_low_i && input_valid_internal_i;
            charger_event_irq_o <= input_voltage_low_i && input_valid_internal_i &&
                                   !vlow_q;
            charger_good_flag_o <= (charger_state_sense_i == 3'h3);
        end
    end

    // ------------------------------------------------------------------
    // Battery thermistor comparators.
    // ------------------------------------------------------------------
    batt_temp_comparator u_hot (
        .clk_i        (clk_i),
        .reset_i      (reset_i),
        .enable_i     (input_valid_internal_i),
        .above_mode_i (1'b1),
        .temp_i       (battery_temp_i),
        .threshold_i  (battery_hot_threshold_i),
        .trip_o       (hot_trip)
    );

    batt_temp_comparator u_cold (
        .clk_i        (clk_i),
        .reset_i      (reset_i),
        .enable_i     (input_valid_internal_i),
        .above_mode_i (1'b0),
        .temp_i       (battery_temp_i),
        .threshold_i  (battery_cold_threshold_i),
        .trip_o       (cold_trip)
    );

    // ------------------------------------------------------------------
    // Die temperature step ladder.
    // ------------------------------------------------------------------
    wire [1:0] depth = step_depth(die_temp_setpoint_select_i);
    wire [7:0] thr1  = step_threshold(die_temp_setpoint_select_i, 2'd1);
    wire [7:0] thr2  = step_threshold(die_temp_setpoint_select_i, 2'd2);
    wire [7:0] thr3  = step_threshold(die_temp_setpoint_select_i, 2'd3);

    always @* begin
        therm_d = therm_q;
        case (therm_q)
            ST_FULL: begin
                if (die_temp_i >= `TEMP_STEP3_C)
                    therm_d = ST_FLOOR;
                else if (depth >= 2'd1 && die_temp_i >= thr1)
                    therm_d = ST_HALF;
            end
            ST_HALF: begin
                if (die_temp_i >= `TEMP_STEP3_C)
                    therm_d = ST_FLOOR;
                else if (depth >= 2'd2 && die_temp_i >= thr2)
                    therm_d = ST_QUARTER;
                else if (die_temp_i < thr1 - `TEMP_HYST_C || depth < 2'd1)
                    therm_d = ST_FULL;
            end
            ST_QUARTER: begin
                if (die_temp_i >= `TEMP_STEP3_C)
                    therm_d = ST_FLOOR;
                else if (depth >= 2'd3 && die_temp_i >= thr3)
                    therm_d = ST_EIGHTH;
                else if (die_temp_i < thr2 - `TEMP_HYST_C || depth < 2'd2)
                    therm_d = ST_HALF;
            end
            ST_EIGHTH: begin
                if (die_temp_i >= `TEMP_STEP3_C)
                    therm_d = ST_FLOOR;
                else if (die_temp_i < thr3 - `TEMP_HYST_C || depth < 2'd3)
                    therm_d = ST_QUARTER;
            end
            ST_FLOOR: begin
                if (die_temp_i < `TEMP_STEP3_REL_C)
                    therm_d = ST_EIGHTH;
            end
            default: therm_d = ST_FULL;
        endcase
    end

    // Shallow setpoints fall through the eighth step on their way back.
    reg [10:0] scaled_ma;
    always @* begin
        case (therm_q)
            ST_HALF:    scaled_ma = cc_current_ma_i >> 1;
            ST_QUARTER: scaled_ma = cc_current_ma_i >> 2;
            ST_EIGHTH:  scaled_ma = cc_current_ma_i >> 3;
            ST_FLOOR:   scaled_ma = `CHG_DEFAULT_MA;
            default:    scaled_ma = cc_current_ma_i;
        endcase
    end

    wire [10:0] cap_ma    = (therm_q == ST_FULL) ? cc_current_ma_i :
                            ((scaled_ma < `CHG_DEFAULT_MA) ? `CHG_DEFAULT_MA : scaled_ma);
    wire [10:0] sel_ma    = (cap_ma > cc_current_ma_i) ? cc_current_ma_i : cap_ma;
    wire [10:0] base_ma   = valid_q ? `CHG_DEFAULT_MA : 11'h000;
    wire [10:0] lim_ma    = (sel_ma < base_ma) ? sel_ma : base_ma;
    wire [10:0] run_ma    = (reduce_ma_q > lim_ma) ? 11'h000 : lim_ma - reduce_ma_q;

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            therm_q              <= ST_FULL;
            thermal_state_irq_o  <= 1'b0;
            thermal_loop_sense_o <= 1'b0;
            charge_target_ma_o   <= 11'h000;
            battery_hot_o        <= 1'b0;
            battery_cold_o       <= 1'b0;
        end else begin
            therm_q              <= therm_d;
            thermal_state_irq_o  <= (therm_d != therm_q);
            thermal_loop_sense_o <= (therm_d != ST_FULL);
            charge_target_ma_o   <= run_ma;
            battery_hot_o        <= hot_trip;
            battery_cold_o       <= cold_trip;
        end
    end

endmodule // charger_input_limit_thermal_regulation
`default_nettype wire

// >>> core/ilim_code_decode.v
`timescale 1ns/100ps
`default_nettype none
`include "charger_ilim_regs.vh"

// ----------------------------------------------------------------------
// Limit code to milliamps lookup.
// ----------------------------------------------------------------------
module ilim_code_decode (
    input  wire [4:0]  code_i,
    output reg  [10:0] limit_ma_o
);
    always @* begin
        case (code_i)
            5'h00:   limit_ma_o = 11'd10;
            5'h01:   limit_ma_o = 11'd15;
            5'h02:   limit_ma_o = 11'd20;
            5'h03:   limit_ma_o = 11'd25;
            5'h04:   limit_ma_o = 11'd30;
            5'h05:   limit_ma_o = 11'd35;
            5'h06:   limit_ma_o = 11'd40;
            5'h07:   limit_ma_o = 11'd45;
            5'h08:   limit_ma_o = 11'd50;
            5'h09:   limit_ma_o = 11'd100;
            5'h0a:   limit_ma_o = 11'd150;
            5'h0b:   limit_ma_o = 11'd200;
            5'h0c:   limit_ma_o = 11'd300;
            5'h0d:   limit_ma_o = 11'd400;
            5'h0e:   limit_ma_o = 11'd500;
            5'h0f:   limit_ma_o = 11'd600;
            5'h10:   limit_ma_o = 11'd700;
            5'h11:   limit_ma_o = 11'd800;
            5'h12:   limit_ma_o = 11'd900;
            5'h13:   limit_ma_o = 11'd1000;
            5'h14:   limit_ma_o = 11'd1500;
            default: limit_ma_o = 11'd100;
        endcase
    end
endmodule // ilim_code_decode
`default_nettype wire

// >>> tb/charge_adapter_model.sv
`timescale 1ns/100ps
`default_nettype none
module charge_adapter_model (
    input  wire logic       clk_i,
    input  wire logic       plug_i,
    input  wire logic       droop_i,
    input  wire logic [3:0] settle_i,
    output var  logic       input_valid_o = 1'b0,
    output var  logic       voltage_low_o = 1'b0
);
    logic [3:0] wait_q = 4'h0;
    // The input only counts as valid once the adapter has been plugged in for settle_i + 1 cycles.
    always @(posedge clk_i) begin
        if (!plug_i) begin
            wait_q        <= 4'h0;
            input_valid_o <= 1'b0;
        end else if (wait_q == settle_i) begin
            input_valid_o <= 1'b1;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
        voltage_low_o <= plug_i && droop_i;
    end
endmodule // charge_adapter_model
`default_nettype wire

// >>> tb/charger_ilim_chk.sv
`timescale 1ns/100ps
`default_nettype none
module charger_ilim_chk (
    input wire logic        clk_i,
    input wire logic        reset_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic        reg_write_i,
    input wire logic        reg_read_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic        input_valid_internal_i,
    input wire logic        charger_operation_select_i,
    input wire logic        input_voltage_low_i,
    input wire logic [2:0]  charger_state_sense_i,
    input wire logic [7:0]  die_temp_i,
    input wire logic        linear_on_o,
    input wire logic        charge_on_o,
    input wire logic        sense_amp_enable_o,
    input wire logic [10:0] charge_target_ma_o,
    input wire logic        charger_event_irq_o,
    input wire logic        thermal_state_irq_o,
    input wire logic        thermal_loop_sense_o,
    input wire logic        charger_good_flag_o,
    input wire logic        battery_hot_o,
    input wire logic        battery_cold_o
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence good_write;
        reg_write_i && reg_addr_i == 8'h94 && reg_wdata_i[7:3] <= 5'h14;
    endsequence
    sequence read_back;
        !reg_write_i ##1 reg_read_i && reg_addr_i == 8'h94;
    endsequence
    code_readback_a: assert property (good_write ##1 read_back |=>
        reg_rdata_o == ($past(reg_wdata_i, 3) & 8'hf8)) else $error("limit code readback wrong");
    unmapped_read_a: assert property (reg_read_i && reg_addr_i != 8'h94 |=>
        reg_rdata_o == 8'h00) else $error("unmapped read not zero");
    sense_amp_a: assert property (!$past(reset_i) |->
        sense_amp_enable_o == $past(input_valid_internal_i)) else $error("sense amp wrong");
    regulator_on_a: assert property (!$past(reset_i) |->
        linear_on_o == ($past(input_valid_internal_i) && !$past(charger_operation_select_i))
        && charge_on_o == ($past(input_valid_internal_i) && $past(charger_operation_select_i)))
        else $error("regulator enable wrong");
    good_flag_a: assert property (!$past(reset_i) |->
        charger_good_flag_o == ($past(charger_state_sense_i) == 3'h3)) else $error("good flag wrong");
    voltage_irq_a: assert property ($rose(input_voltage_low_i) && input_valid_internal_i |=>
        charger_event_irq_o ##1 !charger_event_irq_o) else $error("voltage irq wrong");
    thermal_irq_a: assert property ($changed(thermal_loop_sense_o) |->
        thermal_state_irq_o) else $error("thermal change without irq");
    batt_idle_a: assert property (!input_valid_internal_i [*4] |->
        !battery_hot_o && !battery_cold_o) else $error("battery trip without charger");
    cap_default_a: assert property (charge_target_ma_o <= 11'h064)
        else $error("charge target above cap");
    floor_state_a: assert property (die_temp_i >= 8'h7d [*4] |->
        thermal_loop_sense_o) else $error("hot die not regulated");
endmodule // charger_ilim_chk
bind charger_input_limit_thermal_regulation charger_ilim_chk i_chk (.clk_i, .reset_i,
    .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o, .input_valid_internal_i,
    .charger_operation_select_i, .input_voltage_low_i, .charger_state_sense_i, .die_temp_i,
    .linear_on_o, .charge_on_o, .sense_amp_enable_o, .charge_target_ma_o, .charger_event_irq_o,
    .thermal_state_irq_o, .thermal_loop_sense_o, .charger_good_flag_o, .battery_hot_o,
    .battery_cold_o);
`default_nettype wire

// >>> tb/charger_input_limit_thermal_regulation_tb.sv
`timescale 1ns/100ps
`default_nettype none
module charger_input_limit_thermal_regulation_tb;
    logic        clk_i = 1'b0, reset_i = 1'b1, plug = 1'b0, droop = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
    logic        reg_write_i = 1'b0, reg_read_i = 1'b0, charger_operation_select_i = 1'b0;
    logic        input_valid_internal_i, input_voltage_low_i;
    logic [10:0] charge_current_ma_i = 11'h000, system_load_ma_i = 11'h000;
    logic [10:0] charger_bias_ma_i = 11'h000, cc_current_ma_i = 11'h320, charge_target_ma_o;
    logic [2:0]  charger_state_sense_i = 3'h0;
    logic [1:0]  die_temp_setpoint_select_i = 2'h0;
    logic [7:0]  die_temp_i = 8'h19, battery_temp_i = 8'h19;
    logic [7:0]  battery_hot_threshold_i = 8'h2d, battery_cold_threshold_i = 8'h0a;
    logic        linear_on_o, charge_on_o, sense_amp_enable_o, input_limit_active_o;
    logic        charger_event_irq_o, thermal_state_irq_o, thermal_loop_sense_o;
    logic        charger_good_flag_o, battery_hot_o, battery_cold_o;
    integer      miscompares = 0, checks = 0, seed = 32'h2d6b, evt_cnt = 0, thm_cnt = 0;
    logic [7:0]  bt_tab [6] = '{8'h32, 8'h2c, 8'h28, 8'h05, 8'h0b, 8'h0f};
    logic [1:0]  bx_tab [6] = '{2'b10, 2'b10, 2'b00, 2'b01, 2'b01, 2'b00};

    charger_input_limit_thermal_regulation i_dut (.clk_i, .reset_i, .reg_addr_i, .reg_wdata_i,
        .reg_write_i, .reg_read_i, .reg_rdata_o, .input_valid_internal_i,
        .charger_operation_select_i, .charge_current_ma_i, .system_load_ma_i, .charger_bias_ma_i,
        .input_voltage_low_i, .charger_state_sense_i, .cc_current_ma_i, .die_temp_i,
        .die_temp_setpoint_select_i, .battery_temp_i, .battery_hot_threshold_i,
        .battery_cold_threshold_i, .linear_on_o, .charge_on_o, .sense_amp_enable_o,
        .input_limit_active_o, .charge_target_ma_o, .charger_event_irq_o, .thermal_state_irq_o,
        .thermal_loop_sense_o, .charger_good_flag_o, .battery_hot_o, .battery_cold_o);
    charge_adapter_model i_adapter (.clk_i, .plug_i(plug), .droop_i(droop), .settle_i(4'h3),
        .input_valid_o(input_valid_internal_i), .voltage_low_o(input_voltage_low_i));

    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        evt_cnt <= evt_cnt + (charger_event_irq_o === 1'b1);
        thm_cnt <= thm_cnt + (thermal_state_irq_o === 1'b1);
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge clk_i);
        reg_write_i <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge clk_i);
        reg_read_i <= 1'b0;
        #1;
        d = reg_rdata_o;
    endtask
    function automatic logic [10:0] lim_ma(input logic [4:0] c);
        if (c <= 5'h08) return 11'h00a + 11'(c) * 11'h005;
        if (c <= 5'h0b) return 11'h064 + 11'(c - 5'h09) * 11'h032;
        if (c <= 5'h13) return 11'h12c + 11'(c - 5'h0c) * 11'h064;
        return 11'h5dc;
    endfunction
    task automatic complete_run;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        logic [7:0]  rd, thr;
        logic [10:0] tot, b, ch;
        logic [2:0]  s;
        int          i, base;
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        reg_rd(8'h94, rd);
        check(11'(rd), 11'h068);
        @(posedge clk_i);
        plug <= 1'b1;
        for (i = 0; i < 50 && input_valid_internal_i !== 1'b1; i++) @(posedge clk_i);
        if (i == 50) begin
            miscompares = miscompares + 1;
            complete_run();
        end
        for (int c = 0; c <= 20; c++) begin
            reg_wr(8'h94, {c[4:0], 3'($random(seed))});
            reg_rd(8'h94, rd);
            check(11'(rd), 11'({c[4:0], 3'h0}));
            for (int k = 0; k < 2; k++) begin
                tot = lim_ma(c[4:0]) + 11'(k);
                b = 11'($random(seed) & 32'h7);
                ch = 11'($unsigned($random(seed)) % (tot - b + 1));
                @(posedge clk_i);
                charger_bias_ma_i   <= b;
                charge_current_ma_i <= ch;
                system_load_ma_i    <= tot - b - ch;
                cycles(4);
                check(11'(input_limit_active_o), 11'(k));
                check(charge_target_ma_o, 11'h064 - 11'(k));
            end
        end
        for (int c = 21; c < 32; c++) begin
            reg_wr(8'h94, {c[4:0], 3'h0});
            reg_rd(8'h94, rd);
            check(11'(rd), 11'h0a0);
        end
        reg_wr(8'h95, 8'h48);
        reg_rd(8'h95, rd);
        check(11'(rd), 11'h000);
        for (i = 0; i < 4; i++) begin
            s = (i == 0) ? 3'h3 : 3'($random(seed));
            @(posedge clk_i);
            charger_operation_select_i <= i[0];
            charger_state_sense_i      <= s;
            droop                      <= 1'b1;
            cycles(3);
            check(11'({linear_on_o, charge_on_o}), {9'h000, ~i[0], i[0]});
            check(11'(charger_good_flag_o), 11'(s == 3'h3));
            @(posedge clk_i);
            droop <= 1'b0;
            cycles(2);
        end
        check(11'(evt_cnt), 11'h004);
        for (int sp = 0; sp < 4; sp++) begin
            thr = 8'h50 + 8'(sp) * 8'h0f;
            @(posedge clk_i);
            die_temp_setpoint_select_i <= 2'(sp);
            die_temp_i                 <= thr - 8'h01;
            cycles(8);
            base = thm_cnt;
            check(11'(thermal_loop_sense_o), 11'h000);
            @(posedge clk_i);
            die_temp_i <= thr;
            cycles(4);
            check(11'(thermal_loop_sense_o), 11'h001);
            @(posedge clk_i);
            die_temp_i <= thr - 8'h05;
            cycles(4);
            check(11'(thermal_loop_sense_o), 11'h001);
            @(posedge clk_i);
            die_temp_i <= (sp == 3) ? 8'h77 : thr - 8'h06;
            cycles(8);
            check(11'(thermal_loop_sense_o), 11'h000);
            check(11'(thm_cnt - base), (sp < 3) ? 11'h002 : 11'h005);
        end
        for (i = 0; i < 6; i++) begin
            @(posedge clk_i);
            battery_temp_i <= bt_tab[i];
            cycles(4);
            check(11'({battery_hot_o, battery_cold_o}), 11'(bx_tab[i]));
        end
        @(posedge clk_i);
        battery_temp_i <= 8'h32;
        cycles(4);
        @(posedge clk_i);
        plug <= 1'b0;
        cycles(6);
        check(11'({battery_hot_o, battery_cold_o, sense_amp_enable_o}), 11'h000);
        @(posedge clk_i);
        reset_i <= 1'b1;
        cycles(2);
        @(posedge clk_i);
        reset_i <= 1'b0;
        reg_rd(8'h94, rd);
        check(11'(rd), 11'h068);
        complete_run();
    end
endmodule // charger_input_limit_thermal_regulation_tb
`default_nettype wire
